// file: core/swc_pkg.sv
// package for the standby wake controller: states and timing constants
// assumes a single 10 MHz reference clock and synchronous active-high reset
package swc_pkg;
  localparam int unsigned CLK_PER_CYCLE = 4;
  localparam logic [1:0]  PHASE_RESET   = 2'h0;
  localparam logic [1:0]  PHASE_LAST    = 2'h3;
  localparam logic [11:0] PC_RESET      = 12'h000;
  localparam logic [3:0]  WAKE_ALL_MASK = 4'hF;
  localparam logic [3:0]  WAKE_B3_MASK  = 4'h8;

  typedef enum logic [1:0] {
    SWC_RUN   = 2'b00,
    SWC_HALT  = 2'b01,
    SWC_RESET = 2'b10
  } swc_state_t;
endpackage

// file: core/swc_standby_wake_control.sv
// standby controller: instruction cycle timing, standby entry and wake
// assumes the core raises halt_exec for the cycle of the standby instruction
`timescale 1ns/1ps

// How it works
// - instruction cycle is four system clocks
// - standby entered only if wake input high
// - low clear pin resets device, any mode
// - low selected port-a input ends standby
// - serial completion resumes after standby instruction
// - serial completion wakes only in rc mode, not ceramic
// - port and serial wake only in rc mode
// - every reset restarts program at address zero
module swc_standby_wake_control #(
  parameter int unsigned PC_WIDTH = 12
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // board pins and options
  input  wire logic                external_clear_pin_n,
  input  wire logic [3:0]          port_a,
  input  wire logic                wake_all_bits_opt,
  input  wire logic                rc_osc_mode,
  // core side
  input  wire logic                halt_exec,
  input  wire logic                serial_done,
  // outputs
  output logic                     cycle_strobe,
  output logic                     core_reset,
  output logic                     fetch_enable,
  output logic                     standby,
  output logic [PC_WIDTH-1:0]      pc_load_value,
  output logic                     pc_load
);
  // refused at elaboration; the phase counter is two bits, so four clocks only
  if (PC_WIDTH < 1 || PC_WIDTH > 12) begin : g_bad_width
    $error("PC_WIDTH out of range");
  end
  if (swc_pkg::CLK_PER_CYCLE != 4) begin : g_bad_cycle
    $error("CLK_PER_CYCLE must be four");
  end

  swc_pkg::swc_state_t state, next_state;
  logic [1:0] phase, next_phase;
  logic       next_cycle_strobe, next_core_reset, next_fetch_enable;
  logic       next_standby, next_pc_load;
  logic [3:0] wake_mask;
  logic       wake_level_high, port_wake;

  // option picks bit 3 alone or bits 3 down to 0
  assign wake_mask       = wake_all_bits_opt ? swc_pkg::WAKE_ALL_MASK
                                             : swc_pkg::WAKE_B3_MASK;
  assign wake_level_high = ((port_a & wake_mask) == wake_mask);
  assign port_wake       = ((port_a & wake_mask) != wake_mask);

  always_comb begin
    next_phase        = phase + 2'h1;
    next_cycle_strobe = (phase == swc_pkg::PHASE_LAST);
    next_state        = state;
    next_core_reset   = 1'b0;
    next_pc_load      = 1'b0;
    case (state)
      swc_pkg::SWC_RUN: begin
        if (halt_exec && phase == swc_pkg::PHASE_LAST && wake_level_high) begin
          next_state = swc_pkg::SWC_HALT;
        end
      end
      swc_pkg::SWC_HALT: begin
        next_phase        = swc_pkg::PHASE_RESET;
        next_cycle_strobe = 1'b0;
        // any selected bit low wakes; rc oscillator only
        if (rc_osc_mode && (port_wake || serial_done)) begin
          next_state = swc_pkg::SWC_RUN;
        end
      end
      default: begin
        next_state   = swc_pkg::SWC_RUN;
        next_phase   = swc_pkg::PHASE_RESET;
        next_pc_load = 1'b1;
      end
    endcase
    if (!external_clear_pin_n) begin
      next_state      = swc_pkg::SWC_RESET;
      next_phase      = swc_pkg::PHASE_RESET;
      next_core_reset = 1'b1;
      next_pc_load    = 1'b0;
      next_cycle_strobe = 1'b0;
    end
    next_standby      = (next_state == swc_pkg::SWC_HALT);
    next_fetch_enable = (next_state == swc_pkg::SWC_RUN);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state         <= swc_pkg::SWC_RESET;
      phase         <= swc_pkg::PHASE_RESET;
      cycle_strobe  <= 1'b0;
      core_reset    <= 1'b1;
      fetch_enable  <= 1'b0;
      standby       <= 1'b0;
      pc_load       <= 1'b0;
      pc_load_value <= swc_pkg::PC_RESET[PC_WIDTH-1:0];
    end else begin
      state         <= next_state;
      phase         <= next_phase;
      cycle_strobe  <= next_cycle_strobe;
      core_reset    <= next_core_reset;
      fetch_enable  <= next_fetch_enable;
      standby       <= next_standby;
      pc_load       <= next_pc_load;
      pc_load_value <= swc_pkg::PC_RESET[PC_WIDTH-1:0];
    end
  end

  AST_CYCLE_FOUR: assert property (@(posedge ref_clk)
    disable iff (rst || !external_clear_pin_n)
    (cycle_strobe && fetch_enable && $past(fetch_enable)) |-> ##4 (cycle_strobe || !fetch_enable))
    else $error("instruction cycle not four clocks");
  AST_ENTRY_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(standby)) |-> $past(wake_level_high))
    else $error("standby entered with wake input low");
  AST_CLEAR_RESETS: assert property (@(posedge ref_clk) disable iff (rst)
    (!external_clear_pin_n) |=> (core_reset && !standby))
    else $error("clear pin did not reset");
  AST_PORT_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
    (standby && rc_osc_mode && external_clear_pin_n && !wake_level_high) |=> !standby)
    else $error("port wake ignored");
  AST_SERIAL_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
    (standby && rc_osc_mode && serial_done && external_clear_pin_n)
      |=> (!standby && fetch_enable && !pc_load))
    else $error("serial wake failed or reset pc");
  AST_SERIAL_ANY: assert property (@(posedge ref_clk) disable iff (rst)
    (standby && rc_osc_mode && serial_done) |=> !standby)
    else $error("serial completion did not wake");
  AST_CERAMIC_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    (standby && !rc_osc_mode && external_clear_pin_n) |=> standby)
    else $error("ceramic mode woke without clear");
  AST_PC_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(core_reset) && external_clear_pin_n) |-> (pc_load && pc_load_value == '0))
    else $error("reset did not restart at zero");
  AST_FROZEN: assert property (@(posedge ref_clk) disable iff (rst)
    (standby) |-> (!fetch_enable && (!cycle_strobe || $rose(standby))))
    else $error("fetch active in standby");

  AST_STROBE_SPACING: assert property (@(posedge ref_clk) disable iff (rst)
    (cycle_strobe) |=> (!cycle_strobe) [*3])
    else $error("instruction cycle strobes too close");

  AST_STROBE_PHASE: assert property (@(posedge ref_clk) disable iff (rst)
    (cycle_strobe) |-> (phase == swc_pkg::PHASE_RESET))
    else $error("strobe not at cycle boundary");

  AST_STROBE_RUN: assert property (@(posedge ref_clk) disable iff (rst)
    (cycle_strobe) |-> $past(fetch_enable))
    else $error("strobe without a running cycle");

  AST_ENTRY_ON_LAST: assert property (@(posedge ref_clk) disable iff (rst)
    (fetch_enable && phase != swc_pkg::PHASE_LAST) |=> !standby)
    else $error("standby entered mid cycle");

  AST_REFUSE_LOW: assert property (@(posedge ref_clk) disable iff (rst)
    (fetch_enable && halt_exec && !wake_level_high) |=> !standby)
    else $error("standby entered with wake input low");

  AST_ENTRY_TAKEN: assert property (@(posedge ref_clk) disable iff (rst)
    (fetch_enable && halt_exec && phase == swc_pkg::PHASE_LAST && wake_level_high
      && external_clear_pin_n) |=> (standby && !fetch_enable))
    else $error("standby instruction not taken");

  AST_CLEAR_STOPS: assert property (@(posedge ref_clk) disable iff (rst)
    (!external_clear_pin_n) |=> (!fetch_enable && !pc_load && !cycle_strobe))
    else $error("activity while clear pin low");

  AST_CLEAR_RELEASE: assert property (@(posedge ref_clk) disable iff (rst)
    (core_reset && external_clear_pin_n) |=> (!core_reset && fetch_enable && pc_load))
    else $error("clear release did not restart");

  AST_RESET_NOT_STANDBY: assert property (@(posedge ref_clk) disable iff (rst)
    (core_reset) |-> !standby)
    else $error("standby during reset");

  AST_BIT3_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
    (standby && rc_osc_mode && external_clear_pin_n && !port_a[3]) |=> !standby)
    else $error("bit 3 low did not wake");

  AST_ANY_BIT_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
    (standby && rc_osc_mode && external_clear_pin_n && wake_all_bits_opt
      && port_a != swc_pkg::WAKE_ALL_MASK) |=> !standby)
    else $error("low wake bit ignored");

  AST_LOW_BITS_IGNORED: assert property (@(posedge ref_clk) disable iff (rst)
    (standby && external_clear_pin_n && !wake_all_bits_opt && port_a[3]
      && !serial_done) |=> standby)
    else $error("unselected bit woke");

  AST_RESUME_NO_RESET: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(standby) && fetch_enable) |-> (!core_reset && !pc_load))
    else $error("wake went through reset");

  AST_RESUME_PHASE: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(standby) && fetch_enable) |-> (phase == swc_pkg::PHASE_RESET && !cycle_strobe))
    else $error("wake did not start a fresh cycle");

  AST_CERAMIC_NO_FETCH: assert property (@(posedge ref_clk) disable iff (rst)
    (standby && !rc_osc_mode && external_clear_pin_n) |=> !fetch_enable)
    else $error("fetch resumed in ceramic mode");

  AST_CERAMIC_SERIAL: assert property (@(posedge ref_clk) disable iff (rst)
    (standby && !rc_osc_mode && serial_done && external_clear_pin_n) |=> standby)
    else $error("serial woke in ceramic mode");

  AST_PC_ONCE: assert property (@(posedge ref_clk) disable iff (rst)
    (pc_load) |=> !pc_load)
    else $error("pc load longer than one clock");

  AST_PC_CAUSE: assert property (@(posedge ref_clk) disable iff (rst)
    (pc_load) |-> ($past(core_reset) && !core_reset))
    else $error("pc load without reset");

  AST_PC_VALUE: assert property (@(posedge ref_clk) disable iff (rst)
    (pc_load) |-> (pc_load_value == swc_pkg::PC_RESET[PC_WIDTH-1:0]))
    else $error("pc load value not zero");

  AST_HOLD_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
    (standby && external_clear_pin_n && wake_level_high && !serial_done)
      |=> (standby && !fetch_enable && !cycle_strobe))
    else $error("standby left without a wake");

  AST_EXCLUSIVE: assert property (@(posedge ref_clk) disable iff (rst)
    (!(standby && fetch_enable) && !(core_reset && fetch_enable)))
    else $error("fetch overlaps standby or reset");

  AST_PHASE_FROZEN: assert property (@(posedge ref_clk) disable iff (rst)
    (standby) |-> (phase == swc_pkg::PHASE_RESET))
    else $error("phase moved in standby");
endmodule

// file: testbench/swc_board_model.sv
// board model: wake pins and clear pin of the controller
// assumes the bench asks for levels; port pins stay still in a halt cycle, clear pin still follows
`timescale 1ns/1ps
module swc_board_model (
  // clock and requests
  input  wire logic       ref_clk,
  input  wire logic       halt_exec,
  input  wire logic [3:0] want_port,
  input  wire logic       want_clear_n,
  // board pins
  output logic [3:0]      port_a,
  output logic            external_clear_pin_n
);
  // no bounce: a pin moving here would make entry a coin toss
  always @(posedge ref_clk) begin
    if (!halt_exec) port_a <= want_port;
    external_clear_pin_n <= want_clear_n;
  end
endmodule

// file: testbench/swc_standby_wake_control_bench.sv
// bench: standby entry, pin, serial and clear wakes
// assumes the board model drives port and clear pins
`timescale 1ns/1ps
module swc_standby_wake_control_bench;
  logic        ref_clk = 0, rst = 1, opt = 0, rc = 1, halt = 0, sdone = 0, clr_n = 1;
  logic [3:0]  want = 4'hF, port_a;
  logic        clear_n, strobe, creset, fetch, standby, pc_load, prev = 0;
  logic [11:0] pc_val;
  logic [1:0]  notes[$];
  int          error_cnt = 0, samples_checked = 0, cyc = 0, gap = -1;
  swc_board_model board (.ref_clk(ref_clk), .halt_exec(halt), .want_port(want),
    .want_clear_n(clr_n), .port_a(port_a), .external_clear_pin_n(clear_n));
  swc_standby_wake_control uut (.ref_clk(ref_clk), .rst(rst), .external_clear_pin_n(clear_n),
    .port_a(port_a), .wake_all_bits_opt(opt), .rc_osc_mode(rc), .halt_exec(halt),
    .serial_done(sdone), .cycle_strobe(strobe), .core_reset(creset), .fetch_enable(fetch),
    .standby(standby), .pc_load_value(pc_val), .pc_load(pc_load));
  initial forever #50 ref_clk = ~ref_clk;
  task automatic chk(input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (exp !== got) begin
      error_cnt++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // a change with no note left is compared against an impossible value
  // sampled mid-cycle so registered outputs have settled
  always @(negedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      test_done();
    end else if (!rst) begin
      if (standby !== prev) begin
        chk(notes.size() ? notes.pop_front() : 2'h3, {fetch, standby});
        prev = standby;
      end
      if (strobe === 1'b1) begin
        chk(12'(swc_pkg::CLK_PER_CYCLE - 1), 12'(gap));
        gap = 0;
      end else if (fetch === 1'b1) begin
        gap++;
      end else begin
        gap = -1;
      end
    end
  end
  task automatic halt_cycle();
    @(posedge ref_clk) halt <= 1;
    repeat (4) @(posedge ref_clk);
    halt <= 0;
  endtask
  task automatic wake(input logic [3:0] p, input logic s, input logic c);
    @(posedge ref_clk) want <= p;
    sdone <= s;
    clr_n <= c;
    repeat (3) @(posedge ref_clk);
    want <= 4'hF;
    sdone <= 0;
    clr_n <= 1;
  endtask
  initial begin
    void'($urandom(19));
    repeat (4) @(posedge ref_clk);
    rst <= 0;
    repeat (2) @(posedge ref_clk);
    for (int k = 0; k < 4; k++) begin
      opt <= k[0];
      notes.push_back(2'h1);
      halt_cycle();
      notes.push_back(2'h2);
      if (k < 2) wake(k[0] ? ~(4'h1 << ($urandom % 4)) : 4'h7, 0, 1);
      else wake(4'hF, 1, 1);
      repeat (4) @(posedge ref_clk);
    end
    want <= 4'hE;
    halt_cycle();
    want <= 4'hF;
    rc <= 0;
    notes.push_back(2'h1);
    halt_cycle();
    wake(4'h0, 1, 1);
    notes.push_back(2'h0);
    wake(4'hF, 0, 0);
    @(negedge ref_clk) chk(1, creset);
    for (int i = 0; i < 8 && pc_load !== 1'b1; i++) @(negedge ref_clk);
    chk(1, pc_load);
    chk(swc_pkg::PC_RESET, pc_val);
    repeat (4) @(posedge ref_clk);
    test_done();
  end
endmodule
